//--- src/ppm_pkg.sv
// ppm_pkg: offsets, field positions and reset values of the port power
// management control/status block.
// assumes: AHB-Lite slave with 32-bit data, one word per register.
package ppm_pkg;
   // register byte offsets
   localparam logic [11:0] PPM_PMCS_OFS      = 12'h0c4;
   localparam logic [11:0] PPM_IRQ_STAT_OFS  = 12'h100;
   localparam logic [11:0] PPM_IRQ_MASK_OFS  = 12'h104;
   localparam logic [11:0] PPM_CTRL_OFS      = 12'h108;
   // field positions in power_mgmt_ctl_stat
   localparam int PPM_PS_LSB      = 0;
   localparam int PPM_CTX_BIT     = 3;
   localparam int PPM_WEN_BIT     = 8;
   localparam int PPM_WST_BIT     = 15;
   // power state codes
   localparam logic [1:0] PPM_PS_D0    = 2'h0;
   localparam logic [1:0] PPM_PS_D1    = 2'h1;
   localparam logic [1:0] PPM_PS_D2    = 2'h2;
   localparam logic [1:0] PPM_PS_D3HOT = 2'h3;
   // reset values
   localparam logic [1:0] PPM_PS_RST   = 2'h0;
   localparam logic       PPM_CTX_RST  = 1'h1;
   localparam logic       PPM_WEN_RST  = 1'h0;
   localparam logic       PPM_WST_RST  = 1'h0;
   localparam logic [1:0] PPM_IRQ_RST  = 2'h0;
   localparam logic       PPM_CTX_LOCK_RST = 1'h0;
   // interrupt status bits
   localparam int PPM_IRQ_PS_BIT   = 0;
   localparam int PPM_IRQ_WAKE_BIT = 1;
   // control register bits
   localparam int PPM_CTRL_LOCK_BIT = 0;
   // ahb-lite encodings
   localparam logic [1:0] PPM_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PPM_HTRANS_SEQ    = 2'h3;
   localparam logic [2:0] PPM_HSIZE_WORD    = 3'h2;
endpackage : ppm_pkg

//--- src/ppm_csr.sv
// ppm_csr: power management control/status register of one switch port,
// reached over an ahb-lite slave, with a sticky wake status and interrupt.
// assumes: one clock; reset is the fundamental reset, hot_reset is the
// port's hot reset; wake_gen is a one-cycle pulse from the same clock.
//
// Notes on behaviour
// - power state field bits 1:0 reads back the state and takes writes of 0=D0 or 3=D3hot only; writes of 1 or 2 are ignored.
// - bit 3 reports context kept across D3hot to D0, reset value one.
// - bit 8 wake enable gates wake message requests and resets to zero.
// - wake enable survives hot reset; only fundamental reset clears it.
// - bit 15 wake status sets when the port generates a wake, enable or not, write one clears.
// - forwarding a downstream wake message leaves wake status unchanged.
// - on the upstream port wake status always reads zero.
// - data select and data scale fields read zero and ignore writes.
// - the top data byte reads zero.
// - bus power/clock control enable and B2/B3 support bits read zero.
`timescale 1ns/1ps
`default_nettype none
module ppm_csr
   import ppm_pkg::*;
#(
   parameter bit IS_UPSTREAM = 1'b0
) (
   // clock and resets
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        hot_reset,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // wake events
   input  wire logic        wake_gen,
   input  wire logic        wake_fwd,
   output logic             wake_msg_req,
   // state out to the port
   output logic [1:0]       power_state,
   output logic             context_kept,
   // interrupt
   output logic             irq
);

   initial begin
      if (IS_UPSTREAM !== 1'b0 && IS_UPSTREAM !== 1'b1)
         $error("IS_UPSTREAM must be 0 or 1");
   end

   // address phase capture
   logic        wr_pend_r;
   logic        rd_pend_r;
   logic [11:0] addr_r;
   logic        wr_pend_nxt;
   logic        rd_pend_nxt;

   wire access_ok = hsel && hready && htrans[1];
   assign wr_pend_nxt = access_ok && hwrite;
   assign rd_pend_nxt = access_ok && !hwrite;

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 12'h000;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         if (access_ok)
            addr_r <= haddr[11:0];
      end
   end

   // zero-wait, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // data phase decode
   wire sel_pmcs  = addr_r == PPM_PMCS_OFS;
   wire sel_stat  = addr_r == PPM_IRQ_STAT_OFS;
   wire sel_mask  = addr_r == PPM_IRQ_MASK_OFS;
   wire sel_ctrl  = addr_r == PPM_CTRL_OFS;
   wire wr_pmcs   = wr_pend_r && sel_pmcs;
   wire wr_mask   = wr_pend_r && sel_mask;
   wire wr_ctrl   = wr_pend_r && sel_ctrl;
   wire rd_stat   = rd_pend_r && sel_stat;

   // register state
   logic [1:0] ps_r;
   logic       ctx_r;
   logic       ctx_lock_r;
   logic       wen_r;
   logic       wst_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [1:0] ps_nxt;
   logic       ctx_nxt;
   logic       wen_nxt;
   logic       wst_nxt;
   logic [1:0] irq_stat_nxt;

   wire [1:0] ps_wr     = hwdata[PPM_PS_LSB +: 2];
   wire       ps_legal  = (ps_wr == PPM_PS_D0) || (ps_wr == PPM_PS_D3HOT);
   wire       ps_change = wr_pmcs && ps_legal && (ps_wr != ps_r);
   // only a port that originates a wake sets status; forwarding does not
   wire       wake_set  = wake_gen && !IS_UPSTREAM;
   wire       wst_clr   = wr_pmcs && hwdata[PPM_WST_BIT];

   assign ps_nxt  = (wr_pmcs && ps_legal) ? ps_wr : ps_r;
   assign ctx_nxt = (wr_pmcs && !ctx_lock_r) ? hwdata[PPM_CTX_BIT] : ctx_r;
   assign wen_nxt = wr_pmcs ? hwdata[PPM_WEN_BIT] : wen_r;
   // set wins over a write-one clear in the same cycle
   assign wst_nxt = wake_set | (wst_r & ~wst_clr);

   assign irq_stat_nxt[PPM_IRQ_PS_BIT] =
      ps_change | (irq_stat_r[PPM_IRQ_PS_BIT] & ~rd_stat);
   assign irq_stat_nxt[PPM_IRQ_WAKE_BIT] =
      wake_set | (irq_stat_r[PPM_IRQ_WAKE_BIT] & ~rd_stat);

   // non-sticky fields: either reset loads their reset values
   always_ff @(posedge clock) begin
      if (reset || hot_reset) begin
         ps_r       <= PPM_PS_RST;
         ctx_r      <= PPM_CTX_RST;
         irq_stat_r <= PPM_IRQ_RST;
         irq_mask_r <= PPM_IRQ_RST;
      end else begin
         ps_r       <= ps_nxt;
         ctx_r      <= ctx_nxt;
         irq_stat_r <= irq_stat_nxt;
         if (wr_mask)
            irq_mask_r <= hwdata[1:0];
      end
   end

   // context bit write lock, set once by the loader
   always_ff @(posedge clock) begin
      if (reset)
         ctx_lock_r <= PPM_CTX_LOCK_RST;
      else if (wr_ctrl && hwdata[PPM_CTRL_LOCK_BIT])
         ctx_lock_r <= 1'b1;
   end

   // sticky fields: only the fundamental reset clears them
   always_ff @(posedge clock) begin
      if (reset) begin
         wen_r <= PPM_WEN_RST;
         wst_r <= PPM_WST_RST;
      end else begin
         wen_r <= wen_nxt;
         wst_r <= wst_nxt;
      end
   end

   // read data assembly; unlisted fields stay zero
   logic [31:0] pmcs_rd;
   always_comb begin
      pmcs_rd = 32'h0000_0000;
      pmcs_rd[PPM_PS_LSB +: 2] = ps_r;
      pmcs_rd[PPM_CTX_BIT]     = ctx_r;
      pmcs_rd[PPM_WEN_BIT]     = wen_r;
      pmcs_rd[PPM_WST_BIT]     = wst_r & ~IS_UPSTREAM;
   end

   wire [31:0] rd_mux =
      sel_pmcs ? pmcs_rd :
      sel_stat ? {30'h0000_0000, irq_stat_r} :
      sel_mask ? {30'h0000_0000, irq_mask_r} :
      sel_ctrl ? {31'h0000_0000, ctx_lock_r} : 32'h0000_0000;

   assign hrdata = rd_pend_r ? rd_mux : 32'h0000_0000;

   // outputs
   assign wake_msg_req = wake_set && wen_r;
   assign power_state  = ps_r;
   assign context_kept = ctx_r;
   assign irq          = |(irq_stat_r & irq_mask_r);

endmodule : ppm_csr
`default_nettype wire

//--- test/ppm_csr_props.sv
// ppm_csr_props: port checks for the power register block.
// assumes: one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ppm_csr_props
   import ppm_pkg::*;
(
   // bus, events and state
   input wire logic        clock, reset, hot_reset, hsel, hwrite, hready,
   input wire logic [1:0]  htrans, power_state,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic        hreadyout, hresp, wake_gen, wake_msg_req,
   input wire logic        context_kept
);
   logic        wp_r, rp_r, en_r;
   logic [11:0] ad_r;
   wire         cw = wp_r && ad_r == PPM_PMCS_OFS;
   wire         cr = rp_r && ad_r == PPM_PMCS_OFS;
   // data-phase flags and a shadow of the wake enable
   always_ff @(posedge clock) begin
      wp_r <= !reset && hsel && hready && htrans[1] && hwrite;
      rp_r <= !reset && hsel && hready && htrans[1] && !hwrite;
      ad_r <= haddr[11:0];
      en_r <= !reset && (cw ? hwdata[8] : en_r);
   end
   sequence rsvd_s;
      cw && hwdata[0] != hwdata[1] && !hot_reset;
   endsequence
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   a_ps_legal: assert property (power_state[0] == power_state[1])
      else $error("reserved power state held");
   a_rsvd_keep: assert property (rsvd_s |=> $stable(power_state))
      else $error("reserved code taken");
   a_ps_write: assert property (
      cw && !hot_reset && hwdata[0] == hwdata[1]
      |=> power_state == $past(hwdata[1:0])) else $error("state not set");
   a_zero_flds: assert property (
      cr |-> (hrdata & 32'hffc0_7ef4) == 0) else $error("field not zero");
   a_wen_read: assert property (cr |-> hrdata[8] == en_r)
      else $error("wake enable lost");
   a_wake_req: assert property (wake_msg_req == (wake_gen && en_r))
      else $error("wake request wrong");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer wrong");
   a_ctx_rst: assert property ($fell(reset) |-> context_kept)
      else $error("context bit reset wrong");
endmodule : ppm_csr_props
bind ppm_csr ppm_csr_props u_props (.*);
`default_nettype wire

//--- test/ppm_host.sv
// ppm_host: ahb-lite master in place of configuration software.
// assumes: one slave whose hreadyout is hready; word transfers only.
`timescale 1ns/1ps
`default_nettype none
module ppm_host
   import ppm_pkg::*;
(
   // bus
   input  wire logic        clock, hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel = 1'b0, hwrite = 1'b0,
   output logic [1:0]       htrans = 2'h0,
   output logic [2:0]       hsize = PPM_HSIZE_WORD,
   output logic [31:0]      haddr = 32'h0, hwdata = 32'h0
);
   task automatic hold;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (hready !== 1'b1) test_ppm_csr.close_out(1);
   endtask : hold
   // call just after a rising edge; returns just after one
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= PPM_HTRANS_NONSEQ;
      hwrite <= w;
      hold();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold();
      q = hrdata;
      hwdata <= ~d;
   endtask : xfer
endmodule : ppm_host
`default_nettype wire

//--- test/test_ppm_csr.sv
// test_ppm_csr: register-level test of the port power block.
// assumes: ppm_host drives the bus, this bench the wake events.
`timescale 1ns/1ps
`default_nettype none
module test_ppm_csr
   import ppm_pkg::*;
;
   logic        clock = 0, reset = 1, hot_reset = 0, wake_gen = 0;
   logic        wake_fwd = 0, hsel, hwrite, hready, hreadyout, hresp;
   logic        wake_msg_req, context_kept, irq;
   logic [1:0]  htrans, power_state;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   int          n_mismatch = 0, checks = 0;
   assign hready = hreadyout;
   ppm_host host (.*);
   ppm_csr  dut (.*);
   initial forever #10 clock = ~clock;
   task automatic close_out(input int bad);
      n_mismatch += bad;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic cmp(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : cmp
   task automatic chk(input logic [11:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, q);
      cmp(q, exp);
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic ev(input logic g, f);
      wake_gen <= g;
      wake_fwd <= f;
      @(posedge clock);
      wake_gen <= 1'b0;
      wake_fwd <= 1'b0;
      @(posedge clock);
   endtask : ev
   task automatic rs(input logic fund);
      reset     <= fund;
      hot_reset <= !fund;
      repeat (2) @(posedge clock);
      reset     <= 1'b0;
      hot_reset <= 1'b0;
      @(posedge clock);
   endtask : rs
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk(PPM_PMCS_OFS, 32'h0000_0008);
      wr(PPM_PMCS_OFS, 32'hffff_ffff);
      chk(PPM_PMCS_OFS, 32'h0000_010b);
      for (int c = 1; c < 3; c++) begin
         wr(PPM_PMCS_OFS, 32'h100 | c);
         chk(PPM_PMCS_OFS, 32'h0000_0103);
      end
      ev(1'b0, 1'b1);
      chk(PPM_PMCS_OFS, 32'h0000_0103);
      ev(1'b1, 1'b0);
      chk(PPM_PMCS_OFS, 32'h0000_8103);
      rs(1'b0);
      chk(PPM_PMCS_OFS, 32'h0000_8108);
      wr(PPM_IRQ_MASK_OFS, 32'h0000_0003);
      wr(PPM_PMCS_OFS, 32'h0000_8003);
      #1 cmp({31'h0, irq}, 32'h1);
      chk(PPM_IRQ_STAT_OFS, 32'h0000_0001);
      #1 cmp({31'h0, irq}, 32'h0);
      chk(PPM_PMCS_OFS, 32'h0000_0003);
      ev(1'b1, 1'b0);
      chk(PPM_PMCS_OFS, 32'h0000_8003);
      wr(12'h200, 32'hffff_ffff);
      chk(12'h200, 32'h0);
      rs(1'b1);
      chk(PPM_PMCS_OFS, 32'h0000_0008);
      close_out(0);
   end
endmodule : test_ppm_csr
`default_nettype wire
